// file: hdl/ofc_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants for the oscillator frequency control register bank.
// ---------------------------------------------------------------------------
package ofc_pkg;

    // Byte register addresses as seen on the register port.
    localparam logic [7:0] ADDR_FREQ_B2 = 8'h10;
    localparam logic [7:0] ADDR_FREQ_B1 = 8'h11;
    localparam logic [7:0] ADDR_FREQ_B0 = 8'h12;
    localparam logic [7:0] ADDR_CTRL = 8'h87;
    localparam logic [7:0] ADDR_LOOP = 8'h89;

    // Bit positions inside the control and loop registers.
    localparam int CTRL_RST_BIT = 7;
    localparam int CTRL_NEWF_BIT = 6;
    localparam int CTRL_HOLDW_BIT = 5;
    localparam int CTRL_HOLDADC_BIT = 4;
    localparam int CTRL_RECALL_BIT = 0;
    localparam int LOOP_HOLD_BIT = 4;

    // Widths of the byte array, the frequency word and the ADC word.
    localparam int FREQ_BYTES = 3;
    localparam int FREQ_W = 24;
    localparam int VC_ADC_W = 12;

    // Reset values.
    localparam logic [7:0] FREQ_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [FREQ_W-1:0] WORD_RESET = 24'h000000;
    localparam logic [VC_ADC_W-1:0] ADC_RESET = 12'h000;

    // Timing of the internal logic reset.
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_TIME_NS = 1000;
    localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 6;
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(RST_CYCLES);
    localparam logic [TMR_W-1:0] TMR_ZERO = 6'h00;
    localparam logic [TMR_W-1:0] TMR_ONE = 6'h01;

    // Non-volatile defaults, one per frequency byte, most significant first.
    localparam int NVM_AW = 2;
    localparam logic [NVM_AW-1:0] NVM_IDX_FIRST = 2'h0;
    localparam logic [NVM_AW-1:0] NVM_IDX_MID = 2'h1;
    localparam logic [NVM_AW-1:0] NVM_IDX_LAST = 2'h2;
    localparam logic [NVM_AW-1:0] RCL_STEP_END = 2'h3;
    localparam logic [NVM_AW-1:0] RCL_ONE = 2'h1;
    localparam logic [7:0] NVM_B2 = 8'h2a;
    localparam logic [7:0] NVM_B1 = 8'h5c;
    localparam logic [7:0] NVM_B0 = 8'h91;

    // Sequencer states; recall and reset each differ from idle in one bit.
    typedef enum logic [1:0] {
        OFC_IDLE = 2'b00,
        OFC_RECALL = 2'b01,
        OFC_RESET = 2'b10
    } ofc_state_t;

endpackage

// file: hdl/ofc_op_timer.sv
// ---------------------------------------------------------------------------
// Down counter that times the internal logic reset.
// ---------------------------------------------------------------------------
module ofc_op_timer (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control.
    input wire logic start_i,
    // Status.
    output logic busy_o,
    output logic done_o
);

    logic [ofc_pkg::TMR_W-1:0] cnt_q;
    logic [ofc_pkg::TMR_W-1:0] cnt_d;

    // A start while already busy is ignored so the length stays fixed.
    assign busy_o = (cnt_q != ofc_pkg::TMR_ZERO);
    assign done_o = (cnt_q == ofc_pkg::TMR_ONE);
    assign cnt_d = (start_i && !busy_o) ? ofc_pkg::TMR_LOAD :
                   busy_o ? cnt_q - ofc_pkg::TMR_ONE : cnt_q;

    // Counter register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= ofc_pkg::TMR_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// file: hdl/ofc_nvm_rom.sv
// ---------------------------------------------------------------------------
// Non-volatile default store with registered read data.
// ---------------------------------------------------------------------------
module ofc_nvm_rom (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Read port.
    input wire logic [ofc_pkg::NVM_AW-1:0] addr_i,
    output logic [7:0] rdata_o
);

    logic [7:0] rom_word;

    // Unused addresses return zero.
    assign rom_word = (addr_i == ofc_pkg::NVM_IDX_FIRST) ? ofc_pkg::NVM_B2 :
                      (addr_i == ofc_pkg::NVM_IDX_MID) ? ofc_pkg::NVM_B1 :
                      (addr_i == ofc_pkg::NVM_IDX_LAST) ? ofc_pkg::NVM_B0 : ofc_pkg::BYTE_ZERO;

    // Read data register, one cycle behind the address.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= ofc_pkg::BYTE_ZERO;
        end else begin
            rdata_o <= rom_word;
        end
    end

endmodule

// file: hdl/ofc_regs.sv
// Contract
// RULE1: The three low frequency bytes [23:16], [15:8] and [7:0] are read/write registers that feed the word.
// RULE2: Setting control bit 7 resets all internal logic and floats the clock output meanwhile; here the held ADC word and read data are not reset.
// RULE3: Control bit 7 returns to zero by itself when the internal reset is over.
// RULE4: The internal reset also resets the serial interface, so hosts should not use it to restart.
// RULE5: Writing one to control bit 6 tells the synthesizer loop to take up the new frequency.
// RULE6: Control bit 6 clears itself once the loop reports the new frequency applied.
// RULE7: While control bit 5 is set the frequency word seen by the oscillator stays fixed.
// RULE8: While control bit 4 is set the control-voltage ADC word is held constant.
// RULE9: Control bits 7, 6, 1 and 0 reset to zero, and bits 3 to 1 always read zero.
// RULE10: Writing one to control bit 0 copies the non-volatile defaults into the registers; zero does nothing.
// RULE11: Control bit 0 clears itself when that copy is done.
// RULE12: A recall reloads the registers without touching the serial interface.
// RULE13: While loop register bit 4 is set the synthesizer loop is frozen.
// RULE14: To retune, the host freezes the loop, writes the word, unfreezes, sets bit 6 and waits for it to clear.
module ofc_regs (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port from the serial interface.
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    output logic serial_if_reset_o,
    // Synthesizer loop side.
    input wire logic freq_applied_i,
    output logic apply_frequency_flag_o,
    output logic hold_synth_loop_o,
    output logic [ofc_pkg::FREQ_W-1:0] ref_freq_word_o,
    // Control-voltage ADC.
    input wire logic [ofc_pkg::VC_ADC_W-1:0] vc_adc_word_i,
    output logic hold_vc_adc_word_o,
    output logic [ofc_pkg::VC_ADC_W-1:0] vc_adc_word_o,
    // Clock output driver.
    output logic clk_out_oe_n_o
);

    localparam int RST_LEN = ofc_pkg::RST_CYCLES + 1;

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    ofc_pkg::ofc_state_t state_q;
    ofc_pkg::ofc_state_t state_d;
    logic [7:0] freq_q [ofc_pkg::FREQ_BYTES];
    logic [ofc_pkg::NVM_AW-1:0] rcl_idx_q;
    logic [ofc_pkg::NVM_AW-1:0] rcl_idx_d;
    logic newf_q;
    logic newf_d;
    logic holdw_q;
    logic holdadc_q;
    logic loop_q;
    logic [ofc_pkg::FREQ_W-1:0] word_q;
    logic [ofc_pkg::VC_ADC_W-1:0] adc_q;
    logic [7:0] rdata_q;
    logic [7:0] rom_rdata;
    logic in_rst;
    logic in_rcl;
    logic wr_ok;
    logic wr_ctrl;
    logic wr_loop;
    logic rst_req;
    logic rcl_req;
    logic rcl_load;
    logic rcl_end;
    logic tmr_busy;
    logic tmr_done;
    logic [7:0] ctrl_rb;
    logic [7:0] loop_rb;
    logic [7:0] rd_mux;
    logic [ofc_pkg::FREQ_W-1:0] shadow_word;

    // ------------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------------

    // Writes are dropped while the internal reset runs, since the bytes, word, control and loop bits are held in reset.
    assign in_rst = (state_q == ofc_pkg::OFC_RESET);
    assign in_rcl = (state_q == ofc_pkg::OFC_RECALL);
    assign wr_ok = wr_i && !in_rst;
    assign wr_ctrl = wr_ok && (addr_i == ofc_pkg::ADDR_CTRL);
    assign wr_loop = wr_ok && (addr_i == ofc_pkg::ADDR_LOOP);
    assign rst_req = wr_ctrl && wr_data_i[ofc_pkg::CTRL_RST_BIT] && (state_q == ofc_pkg::OFC_IDLE);
    assign rcl_req = wr_ctrl && wr_data_i[ofc_pkg::CTRL_RECALL_BIT] && (state_q == ofc_pkg::OFC_IDLE);
    assign rcl_load = in_rcl && (rcl_idx_q != ofc_pkg::NVM_IDX_FIRST);
    assign rcl_end = in_rcl && (rcl_idx_q == ofc_pkg::RCL_STEP_END);

    // The self-clearing reset and recall bits read back from the sequencer state.
    assign ctrl_rb = {in_rst, newf_q, holdw_q, holdadc_q, 3'h0, in_rcl}; // see RULE9
    assign loop_rb = {3'h0, loop_q, 4'h0};
    assign rd_mux = (addr_i == ofc_pkg::ADDR_FREQ_B2) ? freq_q[0] :
                    (addr_i == ofc_pkg::ADDR_FREQ_B1) ? freq_q[1] :
                    (addr_i == ofc_pkg::ADDR_FREQ_B0) ? freq_q[2] :
                    (addr_i == ofc_pkg::ADDR_CTRL) ? ctrl_rb :
                    (addr_i == ofc_pkg::ADDR_LOOP) ? loop_rb : ofc_pkg::BYTE_ZERO;
    assign shadow_word = {freq_q[0], freq_q[1], freq_q[2]};

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    ofc_op_timer u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(rst_req),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    ofc_nvm_rom u_nvm (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(rcl_idx_q),
        .rdata_o(rom_rdata)
    );

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------

    // Reset wins over recall when both bits are written together.
    always_comb begin
        state_d = state_q;
        rcl_idx_d = rcl_idx_q;
        case (state_q)
            ofc_pkg::OFC_IDLE: begin
                rcl_idx_d = ofc_pkg::NVM_IDX_FIRST;
                if (rst_req) begin
                    state_d = ofc_pkg::OFC_RESET; // see RULE2
                end else if (rcl_req) begin
                    state_d = ofc_pkg::OFC_RECALL; // see RULE10
                end
            end
            ofc_pkg::OFC_RECALL: begin
                rcl_idx_d = rcl_idx_q + ofc_pkg::RCL_ONE;
                if (rcl_end) begin
                    state_d = ofc_pkg::OFC_IDLE; // see RULE11
                end
            end
            ofc_pkg::OFC_RESET: begin
                if (tmr_done || !tmr_busy) begin
                    state_d = ofc_pkg::OFC_IDLE; // see RULE3
                end
            end
            default: begin
                state_d = ofc_pkg::OFC_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ofc_pkg::OFC_IDLE;
            rcl_idx_q <= ofc_pkg::NVM_IDX_FIRST;
        end else begin
            state_q <= state_d;
            rcl_idx_q <= rcl_idx_d;
        end
    end

    // ------------------------------------------------------------------
    // Frequency bytes.
    // ------------------------------------------------------------------

    // A recall load beats a host write that lands in the same cycle.
    for (genvar g = 0; g < ofc_pkg::FREQ_BYTES; g++) begin : g_freq
        localparam logic [7:0] BYTE_ADDR = ofc_pkg::ADDR_FREQ_B2 + 8'(g);
        localparam logic [ofc_pkg::NVM_AW-1:0] LOAD_STEP = ofc_pkg::NVM_AW'(g + 1);
        logic hit_wr;
        logic hit_load;
        assign hit_wr = wr_ok && (addr_i == BYTE_ADDR);
        assign hit_load = rcl_load && (rcl_idx_q == LOAD_STEP);
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                freq_q[g] <= ofc_pkg::FREQ_RESET;
            end else if (in_rst) begin
                freq_q[g] <= ofc_pkg::FREQ_RESET; // see RULE2
            end else if (hit_load) begin
                freq_q[g] <= rom_rdata; // see RULE10
            end else if (hit_wr) begin
                freq_q[g] <= wr_data_i; // see RULE1
            end
        end
    end

    // ------------------------------------------------------------------
    // Control bits.
    // ------------------------------------------------------------------

    // A new request beats a completion in the same cycle so it is not lost.
    assign newf_d = (wr_ctrl && wr_data_i[ofc_pkg::CTRL_NEWF_BIT]) ? 1'b1 : // see RULE5
                    freq_applied_i ? 1'b0 : newf_q; // see RULE6

    // Control and loop bit registers, cleared by the internal reset too.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            newf_q <= 1'b0;
            holdw_q <= 1'b0;
            holdadc_q <= 1'b0;
            loop_q <= 1'b0;
        end else if (in_rst) begin
            newf_q <= 1'b0;
            holdw_q <= 1'b0;
            holdadc_q <= 1'b0;
            loop_q <= 1'b0;
        end else begin
            newf_q <= newf_d;
            if (wr_ctrl) begin
                holdw_q <= wr_data_i[ofc_pkg::CTRL_HOLDW_BIT];
                holdadc_q <= wr_data_i[ofc_pkg::CTRL_HOLDADC_BIT];
            end
            if (wr_loop) begin
                loop_q <= wr_data_i[ofc_pkg::LOOP_HOLD_BIT]; // see RULE13
            end
        end
    end

    // ------------------------------------------------------------------
    // Held words and read data.
    // ------------------------------------------------------------------

    // The oscillator sees the byte registers only while the word is not held.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_q <= ofc_pkg::WORD_RESET;
            adc_q <= ofc_pkg::ADC_RESET;
            rdata_q <= ofc_pkg::BYTE_ZERO;
        end else begin
            if (in_rst) begin
                word_q <= ofc_pkg::WORD_RESET;
            end else if (!holdw_q) begin
                word_q <= shadow_word; // see RULE7
            end
            if (!holdadc_q) begin
                adc_q <= vc_adc_word_i; // see RULE8
            end
            if (rd_i) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Outputs; the serial front end is reset only by the internal reset.
    assign rd_data_o = rdata_q;
    assign ref_freq_word_o = word_q;
    assign vc_adc_word_o = adc_q;
    assign apply_frequency_flag_o = newf_q;
    assign hold_vc_adc_word_o = holdadc_q;
    assign hold_synth_loop_o = loop_q;
    assign serial_if_reset_o = in_rst; // see RULE4 RULE12
    assign clk_out_oe_n_o = in_rst; // see RULE2

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    property p_freq_wr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_ok && !in_rcl && (addr_i == ofc_pkg::ADDR_FREQ_B0)) |=> (freq_q[2] == $past(wr_data_i));
    endproperty
    a_freq_wr: assert property (p_freq_wr) else $error("frequency byte write lost"); // see RULE1

    property p_rst_hiz;
        @(posedge clk_i) disable iff (!rst_n_i)
        rst_req |=> (clk_out_oe_n_o && serial_if_reset_o) [*8];
    endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("clock output driven during internal reset"); // see RULE2

    property p_rst_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        rst_req |=> ctrl_rb[ofc_pkg::CTRL_RST_BIT] ##[1:RST_LEN] !ctrl_rb[ofc_pkg::CTRL_RST_BIT];
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset bit did not clear"); // see RULE3

    property p_recall_ser;
        @(posedge clk_i) disable iff (!rst_n_i)
        in_rcl |-> !serial_if_reset_o && !clk_out_oe_n_o;
    endproperty
    a_recall_ser: assert property (p_recall_ser) else $error("recall disturbed serial interface"); // see RULE12

    property p_newf_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_ctrl && wr_data_i[ofc_pkg::CTRL_NEWF_BIT]) |=> apply_frequency_flag_o;
    endproperty
    a_newf_set: assert property (p_newf_set) else $error("new frequency flag not set"); // see RULE5

    property p_newf_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (apply_frequency_flag_o && freq_applied_i && !wr_ctrl) |=> !apply_frequency_flag_o;
    endproperty
    a_newf_clear: assert property (p_newf_clear) else $error("new frequency flag not cleared"); // see RULE6

    property p_hold_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        (holdw_q && !in_rst) |=> $stable(ref_freq_word_o);
    endproperty
    a_hold_word: assert property (p_hold_word) else $error("frequency word moved while held"); // see RULE7

    property p_hold_adc;
        @(posedge clk_i) disable iff (!rst_n_i)
        holdadc_q |=> $stable(vc_adc_word_o);
    endproperty
    a_hold_adc: assert property (p_hold_adc) else $error("ADC word moved while held"); // see RULE8

    property p_ctrl_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && (addr_i == ofc_pkg::ADDR_CTRL)) |=> (rd_data_o[3:1] == 3'h0);
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control bits 3 to 1 not zero"); // see RULE9

    property p_recall_copy;
        @(posedge clk_i) disable iff (!rst_n_i)
        rcl_req |=> ##4 (shadow_word == {ofc_pkg::NVM_B2, ofc_pkg::NVM_B1, ofc_pkg::NVM_B0});
    endproperty
    a_recall_copy: assert property (p_recall_copy) else $error("recall did not copy defaults"); // see RULE10

    property p_recall_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        rcl_req |=> ctrl_rb[ofc_pkg::CTRL_RECALL_BIT] [*4] ##1 !ctrl_rb[ofc_pkg::CTRL_RECALL_BIT];
    endproperty
    a_recall_clear: assert property (p_recall_clear) else $error("recall bit did not clear"); // see RULE11

    property p_loop_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_loop |=> (hold_synth_loop_o == $past(wr_data_i[ofc_pkg::LOOP_HOLD_BIT]));
    endproperty
    a_loop_hold: assert property (p_loop_hold) else $error("loop hold bit wrong"); // see RULE13

endmodule

// file: test/ofc_loop_model.sv
// ---------------------------------------------------------------------------
// Synthesizer loop and control-voltage ADC model.
// ---------------------------------------------------------------------------
module ofc_loop_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Loop controls from the register bank, and the answer delay from the bench.
    input wire logic apply_frequency_flag_i,
    input wire logic hold_synth_loop_i,
    input wire logic [3:0] delay_i,
    // Answers to the register bank.
    output logic freq_applied_o,
    output logic [ofc_pkg::VC_ADC_W-1:0] vc_adc_word_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_q;

    // A frozen loop never reports, so a host that skips the unfreeze step waits forever.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 4'h0;
            freq_applied_o <= 1'b0;
        end else if (apply_frequency_flag_i && !hold_synth_loop_i && !freq_applied_o) begin
            wait_q <= (wait_q == delay_i) ? 4'h0 : wait_q + 4'h1;
            freq_applied_o <= (wait_q == delay_i);
        end else begin
            wait_q <= 4'h0;
            freq_applied_o <= 1'b0;
        end
    end

    // The ADC word moves every cycle so that a hold that leaks shows at once.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vc_adc_word_o <= 12'h000;
        end else begin
            vc_adc_word_o <= vc_adc_word_o + 12'h001;
        end
    end
endmodule

// file: test/ofc_regs_test.sv
// ---------------------------------------------------------------------------
// Self-checking bench for the frequency control register bank.
// ---------------------------------------------------------------------------
module ofc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i, rst_n_i, wr_i, rd_i, serial_if_reset_o, freq_applied_i;
    logic apply_frequency_flag_o, hold_synth_loop_o, hold_vc_adc_word_o, clk_out_oe_n_o;
    logic [7:0] addr_i, wr_data_i, rd_data_o, rv;
    logic [ofc_pkg::FREQ_W-1:0] ref_freq_word_o;
    logic [ofc_pkg::VC_ADC_W-1:0] vc_adc_word_i, vc_adc_word_o, adc_s;
    logic [3:0] delay;
    int fail_count, comparisons, oe_cnt, srst_cnt, n;

    ofc_regs i_ofc_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
        .wr_data_i(wr_data_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .serial_if_reset_o(serial_if_reset_o),
        .freq_applied_i(freq_applied_i), .apply_frequency_flag_o(apply_frequency_flag_o),
        .hold_synth_loop_o(hold_synth_loop_o), .ref_freq_word_o(ref_freq_word_o),
        .vc_adc_word_i(vc_adc_word_i), .hold_vc_adc_word_o(hold_vc_adc_word_o),
        .vc_adc_word_o(vc_adc_word_o), .clk_out_oe_n_o(clk_out_oe_n_o));

    ofc_loop_model i_ofc_loop_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .apply_frequency_flag_i(apply_frequency_flag_o), .hold_synth_loop_i(hold_synth_loop_o),
        .delay_i(delay), .freq_applied_o(freq_applied_i), .vc_adc_word_o(vc_adc_word_i));

    // ---------------------------------------------------------------------------
    // Clock, monitors and watchdog.
    // ---------------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Counts cycles with the output floated or the serial side held in reset.
    always @(posedge clk_i) begin
        oe_cnt += (clk_out_oe_n_o === 1'b1);
        srst_cnt += (serial_if_reset_o === 1'b1);
    end

    // The tests take well under a thousand cycles; this allows forty thousand.
    initial begin
        #2000000;
        fail_count++;
        report_and_stop();
    end

    // ---------------------------------------------------------------------------
    // Access and compare tasks.
    // ---------------------------------------------------------------------------
    // A write holds its strobe up, so writes may follow each other every cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_i = 1'b1;
        rd_i = 1'b0;
        addr_i = a;
        wr_data_i = d;
        @(posedge clk_i);
        #1;
    endtask

    task automatic idle();
        wr_i = 1'b0;
        rd_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        wr_i = 1'b0;
        rd_i = 1'b1;
        addr_i = a;
        @(posedge clk_i);
        #1;
        rd_i = 1'b0;
        @(posedge clk_i);
        rv = rd_data_o;
        #1;
    endtask

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_sig(input string nm, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------------------
    // Test sequence.
    // ---------------------------------------------------------------------------
    initial begin
        {wr_i, rd_i, addr_i, wr_data_i, delay} = {2'b00, 8'h00, 8'h00, 4'h1};
        rst_n_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(ofc_pkg::ADDR_CTRL);
        chk_reg("ctrl reset", 8'h00, rv);
        rd(ofc_pkg::ADDR_LOOP);
        chk_reg("loop reset", 8'h00, rv);
        wr(8'h55, 8'hff);
        rd(8'h55);
        chk_reg("unmapped", 8'h00, rv);
        // Back-to-back byte writes assemble the word most significant byte first.
        wr(ofc_pkg::ADDR_FREQ_B2, 8'ha5);
        wr(ofc_pkg::ADDR_FREQ_B1, 8'h3c);
        wr(ofc_pkg::ADDR_FREQ_B0, 8'hf0);
        idle();
        idle();
        chk_sig("word", 24'ha53cf0, ref_freq_word_o);
        rd(ofc_pkg::ADDR_FREQ_B1);
        chk_reg("byte 15_8", 8'h3c, rv);
        // Both holds on, with the always-zero bits written as ones.
        wr(ofc_pkg::ADDR_CTRL, 8'h3e);
        rd(ofc_pkg::ADDR_CTRL);
        chk_reg("ctrl holds", 8'h30, rv);
        chk_sig("adc hold", 24'h1, hold_vc_adc_word_o);
        adc_s = vc_adc_word_o;
        wr(ofc_pkg::ADDR_FREQ_B0, 8'h11);
        repeat (3) idle();
        chk_sig("word held", 24'ha53cf0, ref_freq_word_o);
        chk_sig("adc held", adc_s, vc_adc_word_o);
        rd(ofc_pkg::ADDR_FREQ_B0);
        chk_reg("byte 7_0", 8'h11, rv);
        wr(ofc_pkg::ADDR_CTRL, 8'h00);
        idle();
        idle();
        chk_sig("word free", 24'ha53c11, ref_freq_word_o);
        chk_sig("adc free", 12'(vc_adc_word_i - 12'h001), vc_adc_word_o);
        wr(ofc_pkg::ADDR_LOOP, 8'hff);
        rd(ofc_pkg::ADDR_LOOP);
        chk_reg("loop reg", 8'h10, rv);
        chk_sig("loop hold", 24'h1, hold_synth_loop_o);
        // Retune with a prompt and then a slow loop answer.
        for (int k = 0; k < 2; k++) begin
            delay = (k == 0) ? 4'h1 : 4'h8;
            wr(ofc_pkg::ADDR_LOOP, 8'h10);
            wr(ofc_pkg::ADDR_FREQ_B2, 8'h40 + 8'(k));
            wr(ofc_pkg::ADDR_LOOP, 8'h00);
            wr(ofc_pkg::ADDR_CTRL, 8'h40);
            chk_sig("apply flag", 24'h1, apply_frequency_flag_o);
            n = 0;
            do begin
                rd(ofc_pkg::ADDR_CTRL);
                n++;
            end while (rv[6] === 1'b1 && n < 20);
            chk_reg("apply cleared", 8'h00, rv);
            chk_sig("retuned word", {8'h40 + 8'(k), 16'h3c11}, ref_freq_word_o);
        end
        // Recall: a zero changes nothing, a one loads the stored defaults.
        srst_cnt = 0;
        wr(ofc_pkg::ADDR_CTRL, 8'h00);
        rd(ofc_pkg::ADDR_FREQ_B2);
        chk_reg("no recall", 8'h41, rv);
        wr(ofc_pkg::ADDR_CTRL, 8'h01);
        rd(ofc_pkg::ADDR_CTRL);
        chk_reg("recall busy", 8'h01, rv);
        repeat (6) idle();
        rd(ofc_pkg::ADDR_CTRL);
        chk_reg("recall done", 8'h00, rv);
        chk_sig("recalled word", {ofc_pkg::NVM_B2, ofc_pkg::NVM_B1, ofc_pkg::NVM_B0}, ref_freq_word_o);
        chk_sig("serial kept", 24'h0, 24'(srst_cnt));
        // Internal reset floats the output, drops writes and clears itself.
        oe_cnt = 0;
        wr(ofc_pkg::ADDR_CTRL, 8'h80);
        chk_sig("oe float", 24'h1, clk_out_oe_n_o);
        chk_sig("serial reset", 24'h1, serial_if_reset_o);
        wr(ofc_pkg::ADDR_FREQ_B1, 8'h77);
        rd(ofc_pkg::ADDR_CTRL);
        chk_reg("reset busy", 8'h80, rv);
        n = 0;
        while (serial_if_reset_o === 1'b1 && n < 40) begin
            idle();
            n++;
        end
        idle();
        chk_sig("float cycles", 24'(ofc_pkg::RST_CYCLES), 24'(oe_cnt));
        rd(ofc_pkg::ADDR_CTRL);
        chk_reg("reset done", 8'h00, rv);
        rd(ofc_pkg::ADDR_FREQ_B1);
        chk_reg("byte cleared", 8'h00, rv);
        chk_sig("word cleared", 24'h000000, ref_freq_word_o);
        wr(ofc_pkg::ADDR_FREQ_B1, 8'h5a);
        rd(ofc_pkg::ADDR_FREQ_B1);
        chk_reg("after reset", 8'h5a, rv);
        report_and_stop();
    end
endmodule
